//--- hw/qpd_pkg.sv
package qpd_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned NV_WRITE_MS      = 5;
  localparam int unsigned NV_WRITE_CYCLES  = (NV_WRITE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned WIPER_DELAY_NS   = 100;
  localparam int unsigned WIPER_DELAY_CYC  = WIPER_DELAY_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Address and instruction fields
  // ****************************************************************
  localparam logic [3:0] DEV_TYPE_ID   = 4'hA;  // Arbitrary value
  localparam int unsigned OPC_MSB      = 7;
  localparam int unsigned SLOT_LSB     = 2;
  localparam int unsigned POT_LSB      = 0;
  localparam logic [5:0] WIPER_RST_VAL = 6'h00;
  localparam logic [5:0] SLOT_RST_VAL  = 6'h20;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [3:0] OPC_RD_WIPER  = 4'h9;
  localparam logic [3:0] OPC_WR_WIPER  = 4'hA;
  localparam logic [3:0] OPC_RD_SLOT   = 4'hB;
  localparam logic [3:0] OPC_WR_SLOT   = 4'hC;
  localparam logic [3:0] OPC_SLOT2WIP  = 4'hD;
  localparam logic [3:0] OPC_WIP2SLOT  = 4'hE;
  localparam logic [3:0] OPC_GSLOT2WIP = 4'h1;
  localparam logic [3:0] OPC_GWIP2SLOT = 4'h8;
  localparam logic [3:0] OPC_STEP      = 4'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_INSTR = 3'b011,
    ST_DATA  = 3'b010,
    ST_READ  = 3'b110,
    ST_STEP  = 3'b111,
    ST_WAIT  = 3'b101
  } qpd_state_t;

  typedef struct packed {
    logic       sda_out;
    logic       sda_oe_n;
  } qpd_sda_t;

  typedef struct packed {
    qpd_state_t      st;
    logic [3:0]      bitcnt;
    logic [7:0]      shreg;
    logic [7:0]      instr;
    logic            ack_phase;
    logic            acked;
    logic            nv_pend;
    logic            wp_blk;
    logic [23:0]     busy_cnt;
    logic            nv_init;
    logic [1:0][3:0] sel_s;
    logic [1:0]      wg_s;
    logic [3:0][5:0] wiper;
    logic [3:0][5:0] wiper_out;
    logic [3:0][7:0] dly_cnt;
    qpd_sda_t        sda;
    logic [1:0]      scl_s;
    logic [1:0]      sda_s;
    logic            scl_d;
    logic            sda_d;
  } qpd_regs_t;

endpackage

//--- hw/qpd_decoder.sv
`timescale 1ns/1ns
module qpd_decoder
  import qpd_pkg::*;
#(
  parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // I2C pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Hard-wired select and write guard
  input  wire logic [3:0]  hardwired_select_pins,
  input  wire logic        write_guard_n,
  // Tap selects, one-hot per pot
  output logic [3:0][63:0] tap_sel,
  // Status
  output logic             nv_busy
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  qpd_regs_t r_ff, nxt_r;
  logic [5:0] slots_ff [16];
  logic       slot_we;
  logic [3:0] slot_wa;
  logic [5:0] slot_wd;
  logic       gang_we;
  logic [1:0] gang_slot;

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  logic [3:0] opc;
  logic [1:0] slot, pot;

  assign scl      = r_ff.scl_s[1];
  assign sda      = r_ff.sda_s[1];
  assign scl_rise = scl & ~r_ff.scl_d;
  assign scl_fall = ~scl & r_ff.scl_d;
  assign start_c  = scl & r_ff.scl_d & r_ff.sda_d & ~sda;
  assign stop_c   = scl & r_ff.scl_d & ~r_ff.sda_d & sda;
  assign opc  = r_ff.instr[OPC_MSB -: 4];
  assign slot = r_ff.instr[SLOT_LSB +: 2];
  assign pot  = r_ff.instr[POT_LSB +: 2];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [7:0] b;
    logic       ok;
    b       = {r_ff.shreg[6:0], sda};
    ok      = 1'b0;
    nxt_r   = r_ff;
    slot_we = 1'b0;
    slot_wa = 4'h0;
    slot_wd = 6'h00;
    gang_we = 1'b0;
    gang_slot = 2'h0;
    nxt_r.scl_s = {r_ff.scl_s[0], scl_in};
    nxt_r.sda_s = {r_ff.sda_s[0], sda_in};
    nxt_r.scl_d = scl;
    nxt_r.sda_d = sda;
    nxt_r.sel_s = {r_ff.sel_s[0], hardwired_select_pins};
    nxt_r.wg_s  = {r_ff.wg_s[0], write_guard_n};

    // power-up load from first setting slot
    if (r_ff.nv_init) begin
      for (int p = 0; p < 4; p++) begin
        nxt_r.wiper[p] = slots_ff[p*4];
      end
      nxt_r.nv_init = 1'b0;
    end

    if (r_ff.busy_cnt != 24'h0) begin
      nxt_r.busy_cnt = r_ff.busy_cnt - 24'h1;
    end

    for (int p = 0; p < 4; p++) begin
      if (r_ff.wiper_out[p] == r_ff.wiper[p]) begin
        nxt_r.dly_cnt[p] = 8'h00;
      end else if (r_ff.dly_cnt[p] >= 8'(WIPER_DELAY_CYC - 1)) begin
        nxt_r.wiper_out[p] = r_ff.wiper[p];
        nxt_r.dly_cnt[p]   = 8'h00;
      end else begin
        nxt_r.dly_cnt[p] = r_ff.dly_cnt[p] + 8'h01;
      end
    end

    if (stop_c) begin
      if (r_ff.nv_pend && !r_ff.wp_blk) begin
        nxt_r.busy_cnt = 24'(NV_CYCLES);
        case (opc)
          OPC_WR_SLOT: begin
            slot_we = 1'b1;
            slot_wa = {pot, slot};
            slot_wd = r_ff.shreg[5:0];
          end
          OPC_WIP2SLOT: begin
            slot_we = 1'b1;
            slot_wa = {pot, slot};
            slot_wd = r_ff.wiper[pot];
          end
          OPC_GWIP2SLOT: begin
            gang_we   = 1'b1;
            gang_slot = slot;
          end
          default: begin
            nxt_r.busy_cnt = 24'h0;
          end
        endcase
      end
      nxt_r.st       = ST_IDLE;
      nxt_r.nv_pend  = 1'b0;
      nxt_r.sda      = '{sda_out: 1'b1, sda_oe_n: 1'b1};
    end else if (start_c) begin
      nxt_r.st        = ST_ADDR;
      nxt_r.bitcnt    = 4'h0;
      nxt_r.ack_phase = 1'b0;
      nxt_r.nv_pend   = 1'b0;
      nxt_r.wp_blk    = 1'b0;
      nxt_r.sda       = '{sda_out: 1'b1, sda_oe_n: 1'b1};
    end else if (r_ff.st == ST_STEP) begin
      // step as each SCL pulse ends
      if (scl_fall) begin
        if (sda && r_ff.wiper[pot] != 6'h3F) begin
          nxt_r.wiper[pot] = r_ff.wiper[pot] + 6'h01;
        end else if (!sda && r_ff.wiper[pot] != 6'h00) begin
          nxt_r.wiper[pot] = r_ff.wiper[pot] - 6'h01;
        end
      end
    end else if (r_ff.st != ST_IDLE && r_ff.st != ST_WAIT) begin
      if (scl_rise && !r_ff.ack_phase) begin
        nxt_r.shreg  = b;
        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
      end
      if (r_ff.ack_phase && scl_rise) begin
        nxt_r.acked = ~sda;
      end
      if (scl_fall) begin
        if (r_ff.ack_phase) begin
          nxt_r.ack_phase = 1'b0;
          nxt_r.bitcnt    = 4'h0;
          nxt_r.sda       = '{sda_out: 1'b1, sda_oe_n: 1'b1};
          case (r_ff.st)
            ST_ADDR: nxt_r.st = ST_INSTR;
            ST_INSTR: begin
              case (opc)
                OPC_STEP: nxt_r.st = ST_STEP;
                OPC_RD_WIPER, OPC_RD_SLOT: begin
                  nxt_r.st = ST_READ;
                  nxt_r.sda.sda_out  = r_ff.shreg[7];
                  nxt_r.sda.sda_oe_n = r_ff.shreg[7];
                end
                default: nxt_r.st = ST_DATA;
              endcase
            end
            ST_READ: begin
              // Master NACK ends the read
              nxt_r.st = r_ff.acked ? ST_READ : ST_WAIT;
              if (r_ff.acked) begin
                nxt_r.sda.sda_out  = r_ff.shreg[7];
                nxt_r.sda.sda_oe_n = r_ff.shreg[7];
              end
            end
            default: nxt_r.st = ST_WAIT;
          endcase
        end else if (r_ff.bitcnt == 4'h8) begin
          nxt_r.ack_phase = 1'b1;
          case (r_ff.st)
            ST_ADDR: begin
              ok = (r_ff.shreg[7:4] == DEV_TYPE_ID) && (r_ff.shreg[3:0] == r_ff.sel_s[1])
                   && (r_ff.busy_cnt == 24'h0);
              if (!ok) begin
                nxt_r.st = ST_IDLE;
                nxt_r.ack_phase = 1'b0;
              end
            end
            ST_INSTR: begin
              nxt_r.instr = r_ff.shreg;
              case (r_ff.shreg[7:4])
                OPC_RD_WIPER, OPC_WR_WIPER, OPC_STEP: ok = (r_ff.shreg[3:2] == 2'h0);
                OPC_GSLOT2WIP, OPC_GWIP2SLOT:         ok = (r_ff.shreg[1:0] == 2'h0);
                OPC_RD_SLOT, OPC_WR_SLOT, OPC_SLOT2WIP, OPC_WIP2SLOT: ok = 1'b1;
                default: ok = 1'b0;
              endcase
              if (!ok) begin
                nxt_r.instr = 8'h00;
              end
              case (r_ff.shreg[7:4])
                OPC_SLOT2WIP: nxt_r.wiper[r_ff.shreg[1:0]] = slots_ff[{r_ff.shreg[1:0], r_ff.shreg[3:2]}];
                OPC_GSLOT2WIP: begin
                  if (ok) begin
                    for (int p = 0; p < 4; p++) begin
                      nxt_r.wiper[p] = slots_ff[p*4 + int'(r_ff.shreg[3:2])];
                    end
                  end
                end
                OPC_WIP2SLOT, OPC_GWIP2SLOT: begin
                  nxt_r.nv_pend = ok;
                  nxt_r.wp_blk  = ~r_ff.wg_s[1];
                end
                OPC_RD_WIPER: nxt_r.shreg = {2'h0, r_ff.wiper[r_ff.shreg[1:0]]};
                OPC_RD_SLOT: nxt_r.shreg = {2'h0, slots_ff[{r_ff.shreg[1:0], r_ff.shreg[3:2]}]};
                default: ;
              endcase
            end
            ST_DATA: begin
              // data byte of a three-byte write
              case (opc)
                OPC_WR_WIPER: {ok, nxt_r.wiper[pot]} = {1'b1, r_ff.shreg[5:0]};
                OPC_WR_SLOT: begin
                  ok = r_ff.wg_s[1];
                  nxt_r.nv_pend = ok;
                  if (!ok) begin
                    nxt_r.ack_phase = 1'b0;
                    nxt_r.st = ST_WAIT;
                  end
                end
                default: ;
              endcase
            end
            default: ok = 1'b0;
          endcase
          // Drive the acknowledge low
          if (ok && r_ff.st != ST_READ) begin
            nxt_r.sda = '{sda_out: 1'b0, sda_oe_n: 1'b0};
          end else begin
            nxt_r.sda = '{sda_out: 1'b1, sda_oe_n: 1'b1};
          end
        end else if (r_ff.st == ST_READ) begin
          // Next read bit sits on top after each shift; ones are released
          nxt_r.sda.sda_out  = r_ff.shreg[7];
          nxt_r.sda.sda_oe_n = r_ff.shreg[7];
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // wipers lose value, reloaded after reset
      r_ff         <= '0;
      r_ff.st      <= ST_IDLE;
      r_ff.nv_init <= 1'b1;
      r_ff.sda     <= '{sda_out: 1'b1, sda_oe_n: 1'b1};
      r_ff.scl_s   <= 2'h3;
      r_ff.sda_s   <= 2'h3;
      r_ff.scl_d   <= 1'b1;
      r_ff.sda_d   <= 1'b1;
      r_ff.wiper   <= {4{WIPER_RST_VAL}};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************************************
  // Setting slots, non-volatile across reset
  // ****************************************************************
  // sixteen setting slots
  always_ff @(posedge mclk) begin
    if (slot_we) begin
      slots_ff[slot_wa] <= slot_wd;
    end
    if (gang_we) begin
      for (int p = 0; p < 4; p++) begin
        slots_ff[p*4 + int'(gang_slot)] <= r_ff.wiper[p];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // one-hot tap decode
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      tap_sel[p] = 64'h1 << r_ff.wiper_out[p];
    end
  end
  assign sda_out  = r_ff.sda.sda_out;
  assign sda_oe_n = r_ff.sda.sda_oe_n;
  assign nv_busy  = (r_ff.busy_cnt != 24'h0);

endmodule

//--- tb/qpd_decoder_props.sv
`timescale 1ns/1ns
module qpd_decoder_props
  import qpd_pkg::*;
#(
  parameter int unsigned NV_CYCLES = 200
) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst_n,
  // Serial pins
  input wire logic             scl_in,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe_n,
  // Static inputs
  input wire logic [3:0]       hardwired_select_pins,
  input wire logic             write_guard_n,
  // Outputs
  input wire logic [3:0][63:0] tap_sel,
  input wire logic             nv_busy
);
  logic [23:0] cnt_ff;
  logic [1:0]  rel_ff = 2'h0;
  logic        rd_ff = 1'b0;
  // Busy length and count of reset releases
  always_ff @(posedge mclk) begin
    cnt_ff <= (nv_busy && rst_n) ? cnt_ff + 24'h1 : 24'h0;
    rd_ff  <= rst_n;
    if (rst_n && !rd_ff && rel_ff != 2'h2) begin
      rel_ff <= rel_ff + 2'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_taps_home;
    (tap_sel == {4{64'h1}})[*8];
  endsequence
  sequence s_busy_run;
    nv_busy[*8];
  endsequence
  chk_tap_onehot: assert property (
    rel_ff == 2'h2 |-> $onehot(tap_sel[0]) && $onehot(tap_sel[1]) && $onehot(tap_sel[2]) && $onehot(tap_sel[3]))
    else $error("tap select not one-hot");
  chk_tap_lag: assert property ($rose(rst_n) |-> s_taps_home)
    else $error("tap moved too soon after reset");
  chk_drive_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("SDA driven high");
  chk_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("SDA changed while SCL high");
  chk_busy_quiet: assert property (nv_busy |-> sda_oe_n)
    else $error("SDA driven during programming");
  chk_busy_bound: assert property (cnt_ff <= NV_CYCLES)
    else $error("programming too long");
  chk_busy_run: assert property ($rose(nv_busy) |-> s_busy_run)
    else $error("programming cut short");
  chk_busy_stop: assert property ($rose(nv_busy) |-> scl_in && sda_in)
    else $error("programming began outside stop");
  chk_guard_block: assert property ($rose(nv_busy) |-> $past(write_guard_n, 2))
    else $error("programming while guarded");
endmodule

bind qpd_decoder qpd_decoder_props #(.NV_CYCLES(NV_CYCLES)) i_qpd_decoder_props (
  .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .hardwired_select_pins(hardwired_select_pins),
  .write_guard_n(write_guard_n), .tap_sel(tap_sel), .nv_busy(nv_busy));

//--- tb/qpd_master.sv
`timescale 1ns/1ns
module qpd_master (
  // Clock
  input wire logic mclk,
  // Device drive of SDA
  input wire logic sda_oe_n,
  input wire logic sda_out,
  // Bus wires
  output logic     scl,
  output logic     sda
);
  logic drv = 1'b1;
  // Pulled-up open-drain wire
  assign sda = drv & (sda_oe_n | sda_out);
  initial scl = 1'b1;
  task automatic hw(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One SCL pulse, 48 ns, data set while low
  task automatic bit_io(input logic b, output logic r);
    hw(1);
    drv <= b;
    hw(5);
    scl <= 1'b1;
    hw(6);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    hw(6);
    drv <= 1'b0;
    hw(6);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hw(1);
    drv <= 1'b0;
    hw(5);
    scl <= 1'b1;
    hw(6);
    drv <= 1'b1;
    hw(6);
  endtask
  // Byte out MSB first, then sample acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then no acknowledge
  task automatic rd(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask
endmodule

//--- tb/qpd_decoder_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module qpd_decoder_tb
  import qpd_pkg::*;
;
  localparam int         NV  = 200;
  localparam logic [7:0] ADR = {DEV_TYPE_ID, 4'h6};
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  write_guard_n = 1'b1;
  logic                  scl, sda, sda_out, sda_oe_n, nv_busy, a;
  logic [3:0][63:0]      tap_sel;
  logic [3:0][5:0]       wp;
  logic [3:0][3:0][5:0]  sl;
  logic [7:0]            bad [4] = '{8'hA7, 8'h03, 8'h15, 8'hF0};
  int                    num_errors = 0;
  int                    samples_checked = 0;
  // 250 MHz clock
  always #2 mclk = ~mclk;
  qpd_decoder #(.NV_CYCLES(NV)) i_qpd_decoder (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hardwired_select_pins(4'h6), .write_guard_n(write_guard_n),
    .tap_sel(tap_sel), .nv_busy(nv_busy));
  qpd_master i_qpd_master (.mclk(mclk), .sda_oe_n(sda_oe_n), .sda_out(sda_out), .scl(scl), .sda(sda));
  // Start, address, instruction
  task automatic cmd(input logic [7:0] ins, input logic ik = 1'b1);
    logic k;
    i_qpd_master.start();
    i_qpd_master.wr(ADR, k);
    `CHK(k, 1'b1)
    i_qpd_master.wr(ins, k);
    `CHK(k, ik)
  endtask
  // Bounded wait for programming to end
  task automatic nvwait();
    for (int i = 0; i < NV + 40 && !(nv_busy === 1'b0 && i > 8); i++) @(posedge mclk);
    `CHK(nv_busy, 1'b0)
  endtask
  task automatic wr3(input logic [7:0] ins, input logic [5:0] d, input logic ek);
    logic k;
    cmd(ins);
    i_qpd_master.wr({2'b00, d}, k);
    i_qpd_master.stop();
    `CHK(k, ek)
    if (ins[7:4] == OPC_WR_SLOT && ek) begin
      i_qpd_master.start();
      i_qpd_master.wr(ADR, k);
      i_qpd_master.stop();
      `CHK(k, 1'b0)
    end
    nvwait();
  endtask
  task automatic rd3(input logic [7:0] ins, input logic [5:0] e);
    logic [7:0] v;
    cmd(ins);
    i_qpd_master.rd(v);
    i_qpd_master.stop();
    `CHK(v, {2'b00, e})
  endtask
  task automatic cp2(input logic [7:0] ins, input logic ik = 1'b1);
    cmd(ins, ik);
    i_qpd_master.stop();
    nvwait();
  endtask
  // Wait out the wiper delay, then compare taps
  task automatic taps();
    repeat (WIPER_DELAY_CYC + 8) @(posedge mclk);
    for (int p = 0; p < 4; p++) `CHK(tap_sel[p], 64'h1 << wp[p])
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (12) @(posedge mclk);
    for (int p = 0; p < 4; p++) begin
      wp[p] = 6'(p * 21);
      wr3({OPC_WR_WIPER, 2'b00, 2'(p)}, wp[p], 1'b1);
      rd3({OPC_RD_WIPER, 2'b00, 2'(p)}, wp[p]);
    end
    taps();
    done("wiper");
    for (int p = 0; p < 4; p++) for (int s = 0; s < 4; s++) begin
      sl[p][s] = 6'(p * 16 + s * 4 + 3);
      wr3({OPC_WR_SLOT, 2'(s), 2'(p)}, sl[p][s], 1'b1);
      rd3({OPC_RD_SLOT, 2'(s), 2'(p)}, sl[p][s]);
    end
    done("slots");
    cp2({OPC_SLOT2WIP, 4'hE});
    wp[2] = sl[2][3];
    taps();
    cp2({OPC_GSLOT2WIP, 4'h4});
    for (int p = 0; p < 4; p++) wp[p] = sl[p][1];
    taps();
    wp[0] = 6'h11;
    wr3({OPC_WR_WIPER, 4'h0}, wp[0], 1'b1);
    cp2({OPC_WIP2SLOT, 4'h8});
    rd3({OPC_RD_SLOT, 4'h8}, wp[0]);
    cp2({OPC_GWIP2SLOT, 4'hC});
    for (int p = 0; p < 4; p++) rd3({OPC_RD_SLOT, 2'h3, 2'(p)}, wp[p]);
    done("copy");
    write_guard_n <= 1'b0;
    wr3({OPC_WR_SLOT, 4'h1}, 6'h2A, 1'b0);
    cp2({OPC_WIP2SLOT, 4'h1});
    rd3({OPC_RD_SLOT, 4'h1}, sl[1][0]);
    write_guard_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      i_qpd_master.start();
      i_qpd_master.wr(p ? 8'h36 : {DEV_TYPE_ID, 4'h7}, a);
      i_qpd_master.stop();
      `CHK(a, 1'b0)
    end
    foreach (bad[i]) cp2(bad[i], 1'b0);
    taps();
    done("refuse");
    cmd({OPC_STEP, 4'h1});
    for (int s = 0; s < 4; s++) i_qpd_master.bit_io(s != 3, a);
    i_qpd_master.stop();
    wp[1] = wp[1] + 6'h2;
    taps();
    done("step");
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) wp[p] = sl[p][0];
    taps();
    done("restart");
    summarize();
  end
  // Watchdog, about two and a half times the expected run length
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    summarize();
  end
endmodule
